// ### rtl/wdu_counter.sv
// Prescale counter of the watchdog: counts oscillator ticks up to the selected ratio.
// Assumes tick is a one-cycle pulse on the system clock and clear is level.
`timescale 1ns/10ps
module wdu_counter #(
  parameter int CNT_W = 23
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [4:0] period_sel,
  output logic timeout,
  output logic [CNT_W-1:0] count
);

  // ****************************************************
  // Count and time-out
  // ****************************************************
  logic [CNT_W-1:0] last_q;
  logic at_end;

  assign last_q = CNT_W'(wdu_pkg::last_count(period_sel));
  assign at_end = (count == last_q);

  // Tick counter, restarts at zero after time-out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick) begin
      count <= at_end ? '0 : count + 1'b1;
    end
  end

  // One-cycle time-out pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout <= 1'b0;
    end else begin
      timeout <= tick && !clear && at_end;
    end
  end

  a_rsvd_min_period: assert property (@(posedge clk) disable iff (!rst_n)
    (period_sel > wdu_pkg::PERIOD_MAX_CODE && count == 23'h00001f && tick && !clear)
    |=> timeout && count == '0)
    else $error("reserved period code did not time out at 1:32");

  a_period_2s: assert property (@(posedge clk) disable iff (!rst_n)
    (period_sel == 5'h0b && count == 23'h00ffff && tick && !clear) |=> timeout)
    else $error("code 01011 did not time out at 1:65536");

endmodule

// ### rtl/wdu_pkg.sv
// Constants, field layouts and the period decoder for the watchdog timer unit.
// Assumes a single 10 MHz system clock and an asynchronous low-frequency oscillator pin.
package wdu_pkg;

  // ****************************************************
  // Register map (byte offsets on the plain port)
  // ****************************************************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CLEAR = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_STATE = 4'h4;

  // ****************************************************
  // Control register fields and reset values
  // ****************************************************
  localparam int CTRL_SW_ON_BIT = 0;
  localparam int CTRL_PERIOD_LSB = 1;
  localparam int CTRL_PERIOD_MSB = 5;
  localparam logic [4:0] PERIOD_RESET = 5'h0b;
  localparam logic SW_ON_RESET = 1'b0;

  // Period codes: base shift 5 gives 1:32, last legal code 10010 gives 1:8388608
  localparam logic [4:0] PERIOD_BASE_SHIFT = 5'h05;
  localparam logic [4:0] PERIOD_MAX_CODE = 5'h12;
  localparam logic [22:0] MIN_LAST_COUNT = 23'h00001f;

  // ****************************************************
  // Status / interrupt bit positions
  // ****************************************************
  localparam int EV_RESET_BIT = 0;
  localparam int EV_WAKE_BIT = 1;
  localparam int EV_OSC_FAIL_BIT = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] EV_RESET_VAL = 3'h0;

  // ****************************************************
  // Mode configuration codes
  // ****************************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;

  // ****************************************************
  // Timing: nominal low-frequency oscillator and system clock
  // ****************************************************
  localparam int LFOSC_HZ = 31000;
  localparam int SYS_CLK_HZ = 10000000;
  localparam int SYS_PER_LF_TICK = SYS_CLK_HZ / LFOSC_HZ;

  // Sleep tracking states, Gray coded along awake -> asleep -> hold
  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_ASLEEP = 2'b01,
    ST_HOLD = 2'b11
  } wdu_state_type;

  // Last count value before time-out for a period code
  function automatic logic [22:0] last_count(input logic [4:0] sel);
    logic [23:0] ratio;
    logic [22:0] r;
    ratio = 24'h000001;
    r = MIN_LAST_COUNT;
    if (sel <= PERIOD_MAX_CODE) begin
      ratio = 24'h000001 << 5'(sel + PERIOD_BASE_SHIFT);
      r = ratio[22:0] - 23'h000001;
    end
    return r;
  endfunction

endpackage

// ### rtl/wdu_top.sv
// Watchdog timer unit: mode control, sleep tracking, flags, register port and interrupt.
// Assumes CPU-side inputs are on CLK; LFOSC_CLK is an asynchronous oscillator pin.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps

// How it works
// - Mode 01 runs the watchdog only while the software enable bit is set.
// - Mode 11 keeps the watchdog running always, also in sleep.
// - Mode 10 runs the watchdog awake and stops it in sleep.
// - Software enable is ignored in modes 1x and 00; mode 00 is off.
// - Five-bit period code picks 1:32 doubling up to 1:8388608 at 10010.
// - Period codes 10011 to 11111 give the minimum 1:32 interval.
// - Every reset loads period code 01011, a 1:65536 ratio.
// - Count clears on reset, clear instruction, oscillator fail, disable, start-up timer.
// - Sleep entry clears the count; counting resumes from zero if enabled.
// - Sleep exit clears; crystal clocks hold it clear until start-up timer ends.
// - Changing the internal oscillator divider leaves the count alone.
// - Time-out in sleep wakes instead of resetting and updates both flags.
// - Time-out while awake resets; the CPU must clear it within each period.
// - Time base is the low-frequency oscillator, 32 ticks near one millisecond.
// - Control reads zero in bits 7-6, period in 5-1, enable in bit 0.
module wdu_top #(
  parameter int CNT_W = 23
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LFOSC_CLK,
  input wire logic [1:0] WDT_MODE_CFG,
  input wire logic CLEAR_WATCHDOG_INSTR,
  input wire logic SLEEP_MODE,
  input wire logic OSC_FAIL,
  input wire logic OSC_STARTUP_TIMER_RUN,
  input wire logic CRYSTAL_CLOCK,
  input wire logic INT_OSC_DIVIDER_SEL_WR,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic WDT_RESET,
  output logic WAKE,
  output logic EXPIRY_FLAG_N,
  output logic SLEEP_FLAG_N,
  output logic IRQ
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic lf_s1_q;
  logic lf_s2_q;
  logic lf_s3_q;
  logic lf_tick;
  logic [4:0] period_sel_q;
  logic sw_watchdog_on_q;
  logic [2:0] status_q;
  logic [2:0] irq_en_q;
  logic [2:0] ev_set;
  wdu_pkg::wdu_state_type state_q;
  wdu_pkg::wdu_state_type state_d;
  logic enabled;
  logic sleep_entry;
  logic sleep_exit;
  logic count_clear;
  logic timeout;
  logic [CNT_W-1:0] count;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_irq_en;

  // ****************************************************
  // Oscillator tick: two-stage synchroniser plus edge
  // ****************************************************
  // Stage one feeds only stage two
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lf_s1_q <= 1'b0;
      lf_s2_q <= 1'b0;
      lf_s3_q <= 1'b0;
    end else begin
      lf_s1_q <= LFOSC_CLK;
      lf_s2_q <= lf_s1_q;
      lf_s3_q <= lf_s2_q;
    end
  end

  // One tick per rising oscillator edge
  assign lf_tick = lf_s2_q && !lf_s3_q;

  // ****************************************************
  // Register port decode
  // ****************************************************
  assign wr_ctrl = WR && (ADDR == wdu_pkg::ADDR_CONTROL);
  assign wr_clear = WR && (ADDR == wdu_pkg::ADDR_CLEAR);
  assign wr_irq_en = WR && (ADDR == wdu_pkg::ADDR_IRQ_EN);

  // Control register: period and software enable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      period_sel_q <= wdu_pkg::PERIOD_RESET;
      sw_watchdog_on_q <= wdu_pkg::SW_ON_RESET;
    end else if (wr_ctrl) begin
      period_sel_q <= WDATA[wdu_pkg::CTRL_PERIOD_MSB:wdu_pkg::CTRL_PERIOD_LSB];
      sw_watchdog_on_q <= WDATA[wdu_pkg::CTRL_SW_ON_BIT];
    end
  end

  // Interrupt enable register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_en_q <= wdu_pkg::EV_RESET_VAL;
    end else if (wr_irq_en) begin
      irq_en_q <= WDATA[wdu_pkg::EV_W-1:0];
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        wdu_pkg::ADDR_CONTROL: begin
          RDATA <= {2'b00, period_sel_q, sw_watchdog_on_q};
        end
        wdu_pkg::ADDR_STATUS: begin
          RDATA <= {5'h00, status_q};
        end
        wdu_pkg::ADDR_IRQ_EN: begin
          RDATA <= {5'h00, irq_en_q};
        end
        wdu_pkg::ADDR_STATE: begin
          RDATA <= {2'b00, EXPIRY_FLAG_N, SLEEP_FLAG_N, enabled, 1'b0, state_q};
        end
        default: begin
          RDATA <= 8'h00;
        end
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ****************************************************
  // Mode decode
  // ****************************************************
  // Watchdog running condition per mode
  always_comb begin
    case (WDT_MODE_CFG)
      wdu_pkg::MODE_ALWAYS: begin
        enabled = 1'b1;
      end
      wdu_pkg::MODE_OFF_IN_SLEEP: begin
        enabled = (state_q == wdu_pkg::ST_AWAKE) && !SLEEP_MODE;
      end
      wdu_pkg::MODE_SOFTWARE: begin
        enabled = sw_watchdog_on_q;
      end
      default: begin
        enabled = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // Sleep tracking
  // ****************************************************
  assign sleep_entry = (state_q == wdu_pkg::ST_AWAKE) && SLEEP_MODE;
  assign sleep_exit = (state_q == wdu_pkg::ST_ASLEEP) && !SLEEP_MODE;

  // Next state: asleep, then hold for crystal start-up
  always_comb begin
    case (state_q)
      wdu_pkg::ST_AWAKE: begin
        state_d = SLEEP_MODE ? wdu_pkg::ST_ASLEEP : wdu_pkg::ST_AWAKE;
      end
      wdu_pkg::ST_ASLEEP: begin
        if (SLEEP_MODE) begin
          state_d = wdu_pkg::ST_ASLEEP;
        end else if (CRYSTAL_CLOCK) begin
          state_d = wdu_pkg::ST_HOLD;
        end else begin
          state_d = wdu_pkg::ST_AWAKE;
        end
      end
      wdu_pkg::ST_HOLD: begin
        state_d = OSC_STARTUP_TIMER_RUN ? wdu_pkg::ST_HOLD : wdu_pkg::ST_AWAKE;
      end
      default: begin
        state_d = wdu_pkg::ST_AWAKE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= wdu_pkg::ST_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************
  // Count clearing and counter
  // ****************************************************
  // Divider writes are deliberately absent from this list
  assign count_clear = !enabled
    || CLEAR_WATCHDOG_INSTR
    || OSC_FAIL
    || OSC_STARTUP_TIMER_RUN
    || sleep_entry
    || sleep_exit
    || (state_q == wdu_pkg::ST_HOLD);

  wdu_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(lf_tick),
    .clear(count_clear),
    .period_sel(period_sel_q),
    .timeout(timeout),
    .count(count)
  );

  // ****************************************************
  // Time-out action and status flags
  // ****************************************************
  // Reset request while awake, wake request while asleep
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WDT_RESET <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      WDT_RESET <= timeout && (state_q != wdu_pkg::ST_ASLEEP);
      WAKE <= timeout && (state_q == wdu_pkg::ST_ASLEEP);
    end
  end

  // Active-low expiry flag: time-out drops it, clear instruction restores it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EXPIRY_FLAG_N <= 1'b1;
    end else if (timeout) begin
      EXPIRY_FLAG_N <= 1'b0;
    end else if (CLEAR_WATCHDOG_INSTR) begin
      EXPIRY_FLAG_N <= 1'b1;
    end
  end

  // Active-low sleep flag: sleep entry drops it, clear instruction restores it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SLEEP_FLAG_N <= 1'b1;
    end else if (sleep_entry || (timeout && state_q == wdu_pkg::ST_ASLEEP)) begin
      SLEEP_FLAG_N <= 1'b0;
    end else if (CLEAR_WATCHDOG_INSTR) begin
      SLEEP_FLAG_N <= 1'b1;
    end
  end

  // ****************************************************
  // Interrupt status, clear and output
  // ****************************************************
  assign ev_set[wdu_pkg::EV_RESET_BIT] = timeout && (state_q != wdu_pkg::ST_ASLEEP);
  assign ev_set[wdu_pkg::EV_WAKE_BIT] = timeout && (state_q == wdu_pkg::ST_ASLEEP);
  assign ev_set[wdu_pkg::EV_OSC_FAIL_BIT] = OSC_FAIL;

  // Sticky status, a new event beats a same-cycle clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_q <= wdu_pkg::EV_RESET_VAL;
    end else begin
      status_q <= (status_q & ~(wr_clear ? WDATA[wdu_pkg::EV_W-1:0] : 3'h0)) | ev_set;
    end
  end

  // Level interrupt from enabled status
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_q & irq_en_q);
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_sw_mode_off: assert property (@(posedge CLK) disable iff (!RST_N)
    (WDT_MODE_CFG == 2'h1 && !sw_watchdog_on_q) |=> count == '0)
    else $error("software-off watchdog still counting");

  a_always_on_sleep: assert property (@(posedge CLK) disable iff (!RST_N)
    (WDT_MODE_CFG == 2'h3 && state_q == wdu_pkg::ST_ASLEEP && SLEEP_MODE && lf_tick
     && !CLEAR_WATCHDOG_INSTR && !OSC_FAIL && !OSC_STARTUP_TIMER_RUN && !timeout
     && count != CNT_W'(wdu_pkg::last_count(period_sel_q)))
    |=> count == $past(count) + 1'b1)
    else $error("always-on watchdog stopped in sleep");

  a_sleep_mode_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    (WDT_MODE_CFG == 2'h2 && SLEEP_MODE) |=> count == '0)
    else $error("mode 10 watchdog counting in sleep");

  a_mode_off_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    (WDT_MODE_CFG == 2'h0)[*2]
    |=> (count == '0 && !WDT_RESET) ##1 !WDT_RESET)
    else $error("mode 00 watchdog not idle");

  a_divider_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
    (INT_OSC_DIVIDER_SEL_WR && !count_clear && !lf_tick) |=> count == $past(count))
    else $error("divider write disturbed the count");

  a_reset_period: assert property (@(posedge CLK) disable iff (!RST_N)
    (period_sel_q == wdu_pkg::PERIOD_RESET) |-> wdu_pkg::last_count(period_sel_q) == 23'h00ffff)
    else $error("reset period code is not 1:65536");

  a_tick_single: assert property (@(posedge CLK) disable iff (!RST_N)
    lf_tick |=> !lf_tick)
    else $error("oscillator tick longer than one cycle");

  a_clear_instr_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    (CLEAR_WATCHDOG_INSTR || OSC_FAIL || OSC_STARTUP_TIMER_RUN) |=> count == '0)
    else $error("count not cleared");

  a_entry_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == wdu_pkg::ST_AWAKE && SLEEP_MODE) |=> count == '0 && !SLEEP_FLAG_N)
    else $error("sleep entry did not clear count");

  a_hold_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == wdu_pkg::ST_HOLD) |=> count == '0)
    else $error("count moved during start-up hold");

  a_sleep_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    (timeout && state_q == wdu_pkg::ST_ASLEEP)
    |=> WAKE && !WDT_RESET && !EXPIRY_FLAG_N && !SLEEP_FLAG_N)
    else $error("sleep time-out did not wake");

  a_awake_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    (timeout && state_q != wdu_pkg::ST_ASLEEP) |=> WDT_RESET && !WAKE ##1 !WDT_RESET)
    else $error("awake time-out did not reset");

endmodule

// ### verification/testbench.sv
// Self-checking bench for the watchdog timer unit beside a CPU core model.
// Assumes wdu_pkg, wdu_top and wdu_cpu_model are compiled before it.
`timescale 1ns/10ps
module testbench;
  // ********************
  // Signals and instances
  // ********************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lf_clk = 1'b0;
  logic [1:0] mode = 2'h0;
  logic osc_fail = 1'b0;
  logic osc_startup_timer = 1'b0;
  logic crystal = 1'b0;
  logic div_wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [2:0] cmd_q = 3'h0;
  logic clr_i, slp_i, wdt_rst, wake, exp_n, slp_n, irq, f, w;
  logic [7:0] rdata, d;
  logic [4:0] p;
  logic [1:0] lf_div = 2'h0;
  logic [31:0] rng_a = 32'h5b;
  logic [31:0] rng_b = 32'h5b;
  logic [4:0] pt [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1f};
  logic [3:0] mt [7] = '{4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'hb, 4'hd};
  logic [6:0] mf = 7'b1011100;
  int unsigned tick_cnt = 0;
  int unsigned t0, n;
  int fire_cnt = 0;
  int errors = 0;
  int samples_checked = 0;

  wdu_top dut_u (.CLK(clk), .RST_N(rst_n), .LFOSC_CLK(lf_clk), .WDT_MODE_CFG(mode),
    .CLEAR_WATCHDOG_INSTR(clr_i), .SLEEP_MODE(slp_i), .OSC_FAIL(osc_fail),
    .OSC_STARTUP_TIMER_RUN(osc_startup_timer), .CRYSTAL_CLOCK(crystal), .INT_OSC_DIVIDER_SEL_WR(div_wr),
    .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .WDT_RESET(wdt_rst),
    .WAKE(wake), .EXPIRY_FLAG_N(exp_n), .SLEEP_FLAG_N(slp_n), .IRQ(irq));
  wdu_cpu_model cpu_u (.clk(clk), .rst_n(rst_n), .kick(cmd_q[0]), .sleep_req(cmd_q[1]),
    .wake_req(cmd_q[2]), .wake(wake), .clear_instr(clr_i), .sleep_mode(slp_i));

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int unsigned ratio(input logic [4:0] c);
    if (c <= 5'h12) return 32'h1 << (c + 32'h5);
    return 32'h20;
  endfunction

  // Clock, oscillator pin at a quarter rate, random divider writes, event count
  always #50 clk = ~clk;
  always @(posedge clk) begin
    lf_div <= lf_div + 2'h1;
    lf_clk <= lf_div[1];
    if (lf_div == 2'h2) tick_cnt <= tick_cnt + 1;
    rng_b = xs(rng_b);
    div_wr <= rng_b[0];
    if (wdt_rst === 1'b1 || wake === 1'b1) fire_cnt <= fire_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] c);
    cmd_q <= c;
    @(posedge clk);
    cmd_q <= 3'h0;
    @(posedge clk);
  endtask
  task automatic arm(input logic [1:0] m, input logic [4:0] c, input logic sw);
    mode <= 2'h0;
    wr(wdu_pkg::ADDR_CONTROL, {2'h0, c, sw});
    mode <= m;
  endtask
  task automatic wait_evt(input int lim);
    f = 1'b0;
    w = 1'b0;
    for (int i = 0; i < lim && !f; i++) begin
      @(posedge clk);
      #1;
      f = (wdt_rst === 1'b1) || (wake === 1'b1);
      w = (wake === 1'b1);
    end
  endtask
  task automatic no_fire(input int c);
    int n0;
    #1;
    n0 = fire_cnt;
    repeat (c) @(posedge clk);
    #1;
    chk(fire_cnt, n0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #6000000;
    errors++;
    close_out();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(wdu_pkg::ADDR_CONTROL, d);
    chk(d, 8'h16);
    rd(wdu_pkg::ADDR_STATE, d);
    chk(d, 8'h30);
    rd(4'hf, d);
    chk(d, 8'h00);
    wr(wdu_pkg::ADDR_CONTROL, 8'hff);
    rd(wdu_pkg::ADDR_CONTROL, d);
    chk(d, 8'h3f);
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      rng_a = xs(rng_a);
      p = rng_a[5] ? {3'h0, rng_a[1:0]} : 5'h13 + {1'b0, rng_a[3:0] % 4'hd};
      if (i < 6) p = pt[i];
      arm(2'h3, p, rng_a[6]);
      wait_evt(ratio(p) * 4 + 64);
      t0 = tick_cnt;
      wait_evt(ratio(p) * 4 + 64);
      chk(tick_cnt - t0, ratio(p));
    end
    chk({exp_n, w}, 2'h0);
    $display("test periods done");
    for (int i = 0; i < 7; i++) begin
      if (mt[i][0]) cmd(3'h2);
      arm(mt[i][3:2], 5'h00, mt[i][1]);
      wait_evt(320);
      chk(f, mf[i]);
      if (f) chk(w, mt[i][0]);
      if (f && w) chk({exp_n, slp_n}, 2'h0);
      cmd(3'h4);
    end
    $display("test modes done");
    arm(2'h3, 5'h00, 1'b0);
    fork
      no_fire(280);
      repeat (12) begin
        repeat (20) @(posedge clk);
        cmd(3'h1);
      end
    join
    osc_fail <= 1'b1;
    no_fire(400);
    osc_fail <= 1'b0;
    rd(wdu_pkg::ADDR_STATUS, d);
    chk(d[2], 1'b1);
    osc_startup_timer <= 1'b1;
    no_fire(400);
    osc_startup_timer <= 1'b0;
    $display("test clearing done");
    arm(2'h3, 5'h00, 1'b0);
    repeat (60) @(posedge clk);
    cmd(3'h2);
    #1;
    t0 = tick_cnt;
    wait_evt(300);
    n = tick_cnt - t0;
    chk(w, 1'b1);
    chk(n >= 30 && n <= 34, 1'b1);
    repeat (2) @(posedge clk); // Let the wake pulse end sleep before re-entering
    cmd(3'h2);
    crystal <= 1'b1;
    osc_startup_timer <= 1'b1;
    cmd(3'h4);
    rd(wdu_pkg::ADDR_STATE, d);
    chk(d[1:0], 2'h3);
    no_fire(300);
    osc_startup_timer <= 1'b0;
    t0 = tick_cnt;
    wait_evt(300);
    n = tick_cnt - t0;
    chk(n >= 30 && n <= 35, 1'b1);
    crystal <= 1'b0;
    $display("test sleep done");
    wr(wdu_pkg::ADDR_CLEAR, 8'h07);
    wr(wdu_pkg::ADDR_IRQ_EN, 8'h01);
    #1;
    chk(irq, 1'b0);
    arm(2'h3, 5'h00, 1'b0);
    wait_evt(200);
    mode <= 2'h0;
    repeat (3) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    rd(wdu_pkg::ADDR_STATUS, d);
    chk(d, 8'h01);
    wr(wdu_pkg::ADDR_IRQ_EN, 8'h00);
    #1;
    chk(irq, 1'b0);
    wr(wdu_pkg::ADDR_IRQ_EN, 8'h01);
    #1;
    chk(irq, 1'b1);
    wr(wdu_pkg::ADDR_CLEAR, 8'h01);
    #1;
    chk(irq, 1'b0);
    cmd(3'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({exp_n, slp_n}, 2'h3);
    $display("test interrupt done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(wdu_pkg::ADDR_CONTROL, d);
    chk(d, 8'h16);
    $display("test second reset done");
    close_out();
  end
endmodule

// ### verification/wdu_cpu_model.sv
// CPU core model: issues clear-watchdog instructions and enters or leaves sleep.
// Assumes bench commands are one-cycle pulses on clk; a wake pulse ends sleep.
`timescale 1ns/10ps
module wdu_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic kick,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic wake,
  output logic clear_instr,
  output logic sleep_mode
);
  // Clear instruction one cycle after a kick request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_instr <= 1'b0;
    end else begin
      clear_instr <= kick;
    end
  end

  // Sleep entered on request, left on a wake pulse or request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_mode <= 1'b0;
    end else if (wake || wake_req) begin
      sleep_mode <= 1'b0;
    end else if (sleep_req) begin
      sleep_mode <= 1'b1;
    end
  end
endmodule
